// ===== verilog/rsas_pkg.sv
// constants for the ram sweep address sequencer
// assumes a 32-bit axi4-lite register bus and a 1024-word waveform ram
package rsas_pkg;
  localparam int BUS_AW = 8;
  localparam int RAM_AW = 10;
  localparam int RATE_W = 8;

  // register byte offsets
  localparam logic [BUS_AW-1:0] REG_CTL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_SEG0 = 8'h04;
  localparam logic [BUS_AW-1:0] REG_SEG3 = 8'h10;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h14;

  // first control register fields
  localparam int CTL_RAM_EN = 31;
  localparam int CTL_DEST = 30;
  localparam int CTL_IPC_HI = 29;
  localparam int CTL_IPC_LO = 27;
  localparam int CTL_NO_DWELL = 2;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;

  // segment control word fields
  localparam int SEG_BEG_LO = 0;
  localparam int SEG_FIN_LO = 10;
  localparam int SEG_MODE_LO = 20;
  localparam int SEG_RATE_LO = 24;
  localparam logic [31:0] SEG_RST = 32'h0000_0000;

  // status register fields
  localparam int STAT_ADDR_LO = 0;
  localparam int STAT_PROF_LO = 16;
  localparam int STAT_RUN = 24;
  localparam int STAT_DIR = 25;

  // internal profile control codes
  localparam logic [2:0] IPC_OFF = 3'b000;
  localparam logic [2:0] IPC_INVALID = 3'b111;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    SEG_DIRECT = 3'b000,
    SEG_RAMP_UP = 3'b001,
    SEG_BIDIR = 3'b010,
    SEG_CONT_BIDIR = 3'b011,
    SEG_RECIRC = 3'b100
  } rsas_mode_t;
endpackage

// ===== verilog/rsas_ramp_timer.sv
// reloadable ramp-rate down counter
// assumes load and enable are synchronous to aclk
`timescale 1ns/1ps
module rsas_ramp_timer #(
  parameter int RATE_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic enable,
  input wire logic [RATE_W-1:0] rate,
  // countdown done
  output logic tick
);
  logic [RATE_W-1:0] cnt_q;
  localparam logic [RATE_W-1:0] ONE = RATE_W'(1);

  // a rate of zero behaves as one
  assign tick = enable && !load && (cnt_q <= ONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= rate;
    end else if (enable) begin
      if (cnt_q <= ONE) begin
        cnt_q <= rate;
      end else begin
        cnt_q <= cnt_q - ONE;
      end
    end
  end

  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      (enable && !load && cnt_q == ONE) |=> (cnt_q == $past(rate));
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload");
endmodule

// ===== verilog/rsas_sequencer.sv
// ram sweep address sequencer with axi4-lite registers
// assumes profile pins and update strobe are synchronous to aclk
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
import rsas_pkg::*;

// Overview of operation
// - ram enable plus mode 001 runs ramp-up
// - sweep start loads beginning address and rate
// - each countdown advances address, timer reloads
// - ramp-up stops stepping at final address, no-dwell returns to beginning
// - bidirectional: high pin ignored, low pin direction
// - bidirectional uses profile 0 word only
// - bidirectional entry loads profile 0, starts timer
// - bidirectional tick: up if low pin high
// - low pin toggle makes no register transfer
// - low pin change steps once, reloads timer
// - bidirectional stalls at range end until toggle
// - continuous bidirectional ramps itself, profiles valid
// - up to final, down to beginning, repeat
// - recirculation rises, wraps to beginning at final
// - internal control codes 001-110 disconnect profile pins
// - internal control runs every profile ramp-up
// - codes 001-011 single burst, 000 inactive
// - codes 100-110 loop back, 111 invalid
// - at final jump to next profile beginning
// - burst starts on strobe, ends after last
// - strobe restarts the sweep, as does profile change outside bidirectional and internal control
// - mode 000 and invalid codes hold beginning
// - destination bit picks frequency or phase use
module rsas_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [rsas_pkg::BUS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [rsas_pkg::BUS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host pins
  input wire logic profile_select_low,
  input wire logic profile_select_high,
  input wire logic update_strobe,
  // ram side
  output logic [rsas_pkg::RAM_AW-1:0] ram_addr,
  output logic ram_to_phase,
  output logic [1:0] active_profile,
  output logic sweep_running
);
  import rsas_pkg::*;

  logic [31:0] ctl_buf_q, ctl_q;
  logic [31:0] seg_buf_q [4];
  logic [31:0] seg_q [4];
  logic [BUS_AW-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_have_q, w_have_q;
  logic upd_prev_q, ps_low_prev_q, ps_high_prev_q;
  logic [RAM_AW-1:0] addr_q;
  logic [1:0] prof_q;
  logic dir_up_q, running_q, dest_q;
  logic upd_rise, ps_low_chg, pin_chg, tick, start, bidir_step;
  logic [31:0] start_ctl, start_word, cur, nxt_word;
  logic start_int, start_bidir, int_on, bidir_on, at_fin, at_beg, last_prof;
  logic [1:0] start_prof, pin_prof, ipc_last;
  logic [2:0] ipc;
  rsas_mode_t mode_e;

  function automatic logic [RAM_AW-1:0] beg_of(input logic [31:0] w);
    return w[SEG_BEG_LO +: RAM_AW];
  endfunction
  function automatic logic [RAM_AW-1:0] fin_of(input logic [31:0] w);
    return w[SEG_FIN_LO +: RAM_AW];
  endfunction
  function automatic logic ipc_valid(input logic [31:0] c);
    return c[CTL_RAM_EN] && c[CTL_IPC_HI:CTL_IPC_LO] != IPC_OFF
      && c[CTL_IPC_HI:CTL_IPC_LO] != IPC_INVALID;
  endfunction

  // ---------------- register bus ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (aw_have_q && w_have_q && !s_axi_bvalid) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  wire wr_ctl = aw_addr_q == REG_CTL;
  wire wr_seg = aw_addr_q >= REG_SEG0 && aw_addr_q <= REG_SEG3 && aw_addr_q[1:0] == 2'b00;
  wire [1:0] wr_idx = 2'(aw_addr_q[BUS_AW-1:2] - REG_SEG0[BUS_AW-1:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ctl || wr_seg) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // buffered words, moved to the active set only by the strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_buf_q <= CTL_RST;
      for (int i = 0; i < 4; i++) begin
        seg_buf_q[i] <= SEG_RST;
      end
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b] && wr_ctl) begin
          ctl_buf_q[8*b +: 8] <= w_data_q[8*b +: 8];
        end
        if (w_strb_q[b] && wr_seg) begin
          seg_buf_q[wr_idx][8*b +: 8] <= w_data_q[8*b +: 8];
        end
      end
    end
  end

  wire rd_seg = s_axi_araddr >= REG_SEG0 && s_axi_araddr <= REG_SEG3
    && s_axi_araddr[1:0] == 2'b00;
  wire [1:0] rd_idx = 2'(s_axi_araddr[BUS_AW-1:2] - REG_SEG0[BUS_AW-1:2]);
  logic [31:0] status;
  always_comb begin
    status = '0;
    status[STAT_ADDR_LO +: RAM_AW] = addr_q;
    status[STAT_PROF_LO +: 2] = prof_q;
    status[STAT_RUN] = running_q;
    status[STAT_DIR] = dir_up_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == REG_CTL) begin
        s_axi_rdata <= ctl_buf_q;
      end else if (rd_seg) begin
        s_axi_rdata <= seg_buf_q[rd_idx];
      end else if (s_axi_araddr == REG_STATUS) begin
        s_axi_rdata <= status;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- pins and register transfer ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_prev_q <= 1'b0;
      ps_low_prev_q <= 1'b0;
      ps_high_prev_q <= 1'b0;
    end else begin
      upd_prev_q <= update_strobe;
      ps_low_prev_q <= profile_select_low;
      ps_high_prev_q <= profile_select_high;
    end
  end

  assign upd_rise = update_strobe && !upd_prev_q;
  assign ps_low_chg = profile_select_low != ps_low_prev_q;
  assign pin_chg = ps_low_chg || (profile_select_high != ps_high_prev_q);
  assign pin_prof = {profile_select_high, profile_select_low};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= CTL_RST;
      for (int i = 0; i < 4; i++) begin
        seg_q[i] <= SEG_RST;
      end
    end else if (upd_rise) begin
      ctl_q <= ctl_buf_q;
      seg_q <= seg_buf_q;
    end
  end

  // ---------------- sweep control ----------------
  assign int_on = ipc_valid(ctl_q);
  assign bidir_on = ctl_q[CTL_RAM_EN] && !int_on
    && seg_q[0][SEG_MODE_LO +: 3] == SEG_BIDIR;
  assign ipc = ctl_q[CTL_IPC_HI:CTL_IPC_LO];
  assign ipc_last = ipc[2] ? 2'(ipc[1:0] + 2'd1) : ipc[1:0];
  assign cur = seg_q[prof_q];
  assign nxt_word = seg_q[2'(prof_q + 2'd1)];
  assign at_fin = addr_q == fin_of(cur);
  assign at_beg = addr_q == beg_of(cur);
  assign last_prof = prof_q == ipc_last;

  always_comb begin
    start_ctl = upd_rise ? ctl_buf_q : ctl_q;
    start_int = ipc_valid(start_ctl);
    start_bidir = !start_int && start_ctl[CTL_RAM_EN]
      && (upd_rise ? seg_buf_q[0][SEG_MODE_LO +: 3] : seg_q[0][SEG_MODE_LO +: 3]) == SEG_BIDIR;
    start_prof = (start_int || start_bidir) ? 2'd0 : pin_prof;
    start_word = upd_rise ? seg_buf_q[start_prof] : seg_q[start_prof];
  end

  // pins restart only when they select profiles
  assign start = upd_rise || (pin_chg && !int_on && !bidir_on);
  assign bidir_step = bidir_on && ps_low_chg && !upd_rise && running_q;

  always_comb begin
    if (int_on) begin
      mode_e = SEG_RAMP_UP;
    end else begin
      unique case (cur[SEG_MODE_LO +: 3])
        SEG_RAMP_UP: mode_e = SEG_RAMP_UP;
        SEG_BIDIR: mode_e = SEG_BIDIR;
        SEG_CONT_BIDIR: mode_e = SEG_CONT_BIDIR;
        SEG_RECIRC: mode_e = SEG_RECIRC;
        default: mode_e = SEG_DIRECT;
      endcase
    end
  end

  rsas_ramp_timer #(
    .RATE_W(RATE_W)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(start || bidir_step),
    .enable(running_q),
    .rate(start ? start_word[SEG_RATE_LO +: RATE_W] : cur[SEG_RATE_LO +: RATE_W]),
    .tick(tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= '0;
      prof_q <= '0;
      dir_up_q <= 1'b1;
      running_q <= 1'b0;
    end else if (start) begin
      addr_q <= beg_of(start_word);
      prof_q <= start_prof;
      dir_up_q <= 1'b1;
      running_q <= start_ctl[CTL_RAM_EN];
    end else if (bidir_step) begin
      dir_up_q <= profile_select_low;
      if (profile_select_low && !at_fin) begin
        addr_q <= addr_q + 1'b1;
      end else if (!profile_select_low && !at_beg) begin
        addr_q <= addr_q - 1'b1;
      end
    end else if (running_q && tick) begin
      unique case (mode_e)
        SEG_RAMP_UP: begin
          if (!at_fin) begin
            addr_q <= addr_q + 1'b1;
          end else if (int_on && last_prof && !ipc[2]) begin
            running_q <= 1'b0;
          end else if (int_on && last_prof) begin
            prof_q <= '0;
            addr_q <= beg_of(seg_q[0]);
          end else if (int_on) begin
            prof_q <= 2'(prof_q + 2'd1);
            addr_q <= beg_of(nxt_word);
          end else if (ctl_q[CTL_NO_DWELL]) begin
            addr_q <= beg_of(cur);
          end
        end
        SEG_BIDIR: begin
          dir_up_q <= profile_select_low;
          if (profile_select_low && !at_fin) begin
            addr_q <= addr_q + 1'b1;
          end else if (!profile_select_low && !at_beg) begin
            addr_q <= addr_q - 1'b1;
          end
        end
        SEG_CONT_BIDIR: begin
          if (dir_up_q && at_fin) begin
            dir_up_q <= 1'b0;
            addr_q <= addr_q - 1'b1;
          end else if (!dir_up_q && at_beg) begin
            dir_up_q <= 1'b1;
            addr_q <= addr_q + 1'b1;
          end else if (dir_up_q) begin
            addr_q <= addr_q + 1'b1;
          end else begin
            addr_q <= addr_q - 1'b1;
          end
        end
        SEG_RECIRC: begin
          addr_q <= at_fin ? beg_of(cur) : addr_q + 1'b1;
        end
        SEG_DIRECT: begin
          addr_q <= beg_of(cur);
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_q <= 1'b0;
    end else begin
      dest_q <= ctl_q[CTL_DEST];
    end
  end

  assign ram_addr = addr_q;
  assign active_profile = prof_q;
  assign sweep_running = running_q;
  assign ram_to_phase = dest_q;

  // ---------------- checks ----------------
  property p_start;
    @(posedge aclk) disable iff (!aresetn)
      start |=> (addr_q == $past(beg_of(start_word)) && prof_q == $past(start_prof));
  endproperty
  a_start: assert property (p_start) else $error("sweep start address wrong");

  property p_hold_final;
    @(posedge aclk) disable iff (!aresetn)
      (tick && running_q && !start && !bidir_on && !int_on && mode_e == SEG_RAMP_UP
        && at_fin && !ctl_q[CTL_NO_DWELL]) |=> $stable(addr_q);
  endproperty
  a_hold_final: assert property (p_hold_final) else $error("ramp-up passed final");

  property p_bidir_prof;
    @(posedge aclk) disable iff (!aresetn)
      (bidir_on && !upd_rise) |=> (prof_q == $past(prof_q));
  endproperty
  a_bidir_prof: assert property (p_bidir_prof) else $error("high pin moved profile");

  property p_bidir_step;
    @(posedge aclk) disable iff (!aresetn)
      (bidir_step && (profile_select_low ? !at_fin : !at_beg))
        |=> (addr_q == ($past(profile_select_low) ? $past(addr_q) + 1'b1
          : $past(addr_q) - 1'b1));
  endproperty
  a_bidir_step: assert property (p_bidir_step) else $error("no step on toggle");

  property p_bidir_stall;
    @(posedge aclk) disable iff (!aresetn)
      (bidir_on && running_q && !start && !ps_low_chg && !profile_select_low && at_beg)
        |=> $stable(addr_q);
  endproperty
  a_bidir_stall: assert property (p_bidir_stall) else $error("bidir left beginning");

  property p_recirc;
    @(posedge aclk) disable iff (!aresetn)
      (running_q && tick && !start && !bidir_step && mode_e == SEG_RECIRC && at_fin)
        |=> (addr_q == $past(beg_of(cur)));
  endproperty
  a_recirc: assert property (p_recirc) else $error("recirculation did not wrap");

  property p_pins_off;
    @(posedge aclk) disable iff (!aresetn)
      (int_on && pin_chg && !upd_rise && !tick) |=> ($stable(addr_q) && $stable(prof_q));
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins acted under internal control");

  property p_burst_end;
    @(posedge aclk) disable iff (!aresetn)
      (int_on && running_q && tick && !start && at_fin && last_prof && !ipc[2])
        |=> (!running_q ##1 (!running_q || $past(upd_rise)));
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst did not stop");

  property p_next_prof;
    @(posedge aclk) disable iff (!aresetn)
      (int_on && running_q && tick && !start && at_fin && !last_prof)
        |=> (prof_q == 2'($past(prof_q) + 2'd1) && addr_q == $past(beg_of(nxt_word)));
  endproperty
  a_next_prof: assert property (p_next_prof) else $error("no jump to next profile");

  property p_dest;
    @(posedge aclk) disable iff (!aresetn)
      upd_rise |=> ##1 (ram_to_phase == $past(ctl_buf_q[CTL_DEST], 2));
  endproperty
  a_dest: assert property (p_dest) else $error("destination not followed");
endmodule

// ===== verification/rsas_host_model.sv
// host controller model: drives the profile pins and the transfer strobe
// assumes the bench calls its tasks; pins change by nba at rising aclk
`timescale 1ns/1ps
module rsas_host_model (
  // clock
  input wire logic aclk,
  // host pins
  output logic profile_select_low,
  output logic profile_select_high,
  output logic update_strobe
);
  initial begin
    profile_select_low = 1'b0;
    profile_select_high = 1'b0;
    update_strobe = 1'b0;
  end
  // one rise, then a low sample so the next rise is seen
  task automatic strobe();
    @(posedge aclk);
    update_strobe <= 1'b1;
    @(posedge aclk);
    update_strobe <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic set_pins(input logic [1:0] p);
    @(posedge aclk);
    profile_select_high <= p[1];
    profile_select_low <= p[0];
  endtask
endmodule

// ===== verification/rsas_sequencer_tb.sv
// self-checking bench for the ram sweep address sequencer
// assumes rsas_pkg, the sequencer and the host pin model are compiled first
`timescale 1ns/1ps
module ram_sweep_address_sequencer_tb;
  import rsas_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [BUS_AW-1:0] awaddr;
  logic awvalid;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic bready;
  logic [BUS_AW-1:0] araddr;
  logic arvalid;
  logic rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic ps_low, ps_high, strobe;
  logic [RAM_AW-1:0] ram_addr;
  logic ram_to_phase, sweep_running;
  logic [1:0] active_profile;
  int failures = 0;
  int n_tests = 0;
  int cycle_cnt = 0;
  localparam logic [31:0] EN = 32'h8000_0000;
  always #2.5 aclk = ~aclk;
  rsas_sequencer i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .profile_select_low(ps_low), .profile_select_high(ps_high), .update_strobe(strobe),
    .ram_addr(ram_addr), .ram_to_phase(ram_to_phase),
    .active_profile(active_profile), .sweep_running(sweep_running)
  );
  rsas_host_model i_host (
    .aclk(aclk), .profile_select_low(ps_low),
    .profile_select_high(ps_high), .update_strobe(strobe)
  );
  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input bit ok, input string m);
    n_tests++;
    if (!ok) begin
      failures++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // beginning kept below final by every caller
  function automatic logic [31:0] seg(input int b, input int f, input logic [2:0] m,
                                      input int r);
    return (32'(r) << SEG_RATE_LO) | (32'(m) << SEG_MODE_LO) | (32'(f) << SEG_FIN_LO) | 32'(b);
  endfunction
  task automatic axi_wr(input logic [BUS_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bvalid === 1'b1 && bresp === er, "write response");
  endtask
  task automatic axi_rd(input logic [BUS_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic tick();
    @(posedge aclk);
    #1;
  endtask
  task automatic wait_addr(input logic [RAM_AW-1:0] v);
    int n;
    n = 0;
    while (ram_addr !== v && n < 100) begin
      tick();
      n++;
    end
    chk(ram_addr === v, "start address not reached");
  endtask
  // gap 0 leaves the spacing unchecked
  task automatic step(input logic [RAM_AW-1:0] nxt, input int gap);
    logic [RAM_AW-1:0] a;
    int n;
    a = ram_addr;
    n = 0;
    while (ram_addr === a && n < 400) begin
      tick();
      n++;
    end
    chk(ram_addr === nxt && (gap == 0 || n == gap), "wrong address step");
  endtask
  task automatic hold(input int n);
    logic [RAM_AW-1:0] a;
    bit same;
    a = ram_addr;
    same = 1'b1;
    repeat (n) begin
      tick();
      if (ram_addr !== a) same = 1'b0;
    end
    chk(same, "address moved while holding");
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    chk(ram_addr === '0 && active_profile === 2'b00 && sweep_running === 1'b0, "reset outputs");
    axi_rd(REG_CTL, d, r);
    chk(d === CTL_RST && r === RESP_OKAY, "control reset value");
    axi_rd(REG_SEG0, d, r);
    chk(d === SEG_RST && r === RESP_OKAY, "segment reset value");
    axi_wr(8'h18, 32'h1, RESP_SLVERR);
    axi_rd(8'h18, d, r);
    chk(d === 32'h0 && r === RESP_SLVERR, "unmapped read");
    axi_wr(REG_SEG3, 32'h5a5a_a5a5, RESP_OKAY);
    axi_rd(REG_SEG3, d, r);
    chk(d === 32'h5a5a_a5a5 && r === RESP_OKAY, "segment readback");
    wstrb <= 4'h3;
    axi_wr(REG_SEG3, 32'h1234_5678, RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(REG_SEG3, d, r);
    chk(d === 32'h5a5a_5678 && r === RESP_OKAY, "byte lane write");
  endtask
  task automatic t_sweeps();
    axi_wr(REG_SEG0, seg(4, 6, SEG_RAMP_UP, 2), RESP_OKAY);
    axi_wr(REG_SEG0 + 8'h04, seg(20, 22, SEG_CONT_BIDIR, 2), RESP_OKAY);
    axi_wr(REG_SEG0 + 8'h08, seg(30, 31, SEG_RECIRC, 2), RESP_OKAY);
    axi_wr(REG_SEG3, seg(40, 45, SEG_DIRECT, 1), RESP_OKAY);
    axi_wr(REG_CTL, EN, RESP_OKAY);
    i_host.strobe();
    wait_addr(4);
    chk(sweep_running === 1'b1, "sweep not running");
    // strobe returns one edge into the first countdown
    step(5, 1);
    step(6, 2);
    hold(8);
    i_host.set_pins(2'd1);
    wait_addr(20);
    chk(active_profile === 2'd1, "active profile");
    step(21, 2);
    step(22, 2);
    step(21, 2);
    step(20, 2);
    step(21, 2);
    i_host.set_pins(2'd2);
    wait_addr(30);
    step(31, 2);
    step(30, 2);
    step(31, 2);
    i_host.set_pins(2'd3);
    wait_addr(40);
    hold(8);
  endtask
  task automatic t_nodwell();
    axi_wr(REG_CTL, EN | (32'h1 << CTL_NO_DWELL), RESP_OKAY);
    i_host.strobe();
    i_host.set_pins(2'd0);
    wait_addr(4);
    step(5, 2);
    step(6, 2);
    step(4, 2);
  endtask
  task automatic t_bidir();
    axi_wr(REG_SEG0, seg(8, 10, SEG_BIDIR, 3), RESP_OKAY);
    i_host.set_pins(2'd3);
    i_host.strobe();
    wait_addr(8);
    step(9, 2);
    step(10, 3);
    hold(8);
    i_host.set_pins(2'd2);
    step(9, 0);
    step(8, 3);
    hold(8);
    i_host.set_pins(2'd0);
    hold(8);
  endtask
  task automatic t_internal();
    logic [RAM_AW-1:0] pb [4];
    logic [31:0] d;
    logic [1:0] r;
    int last;
    pb = '{10'd4, 10'd20, 10'd30, 10'd40};
    axi_wr(REG_SEG0, seg(4, 5, SEG_DIRECT, 2), RESP_OKAY);
    axi_wr(REG_SEG0 + 8'h04, seg(20, 21, SEG_CONT_BIDIR, 2), RESP_OKAY);
    axi_wr(REG_SEG0 + 8'h08, seg(30, 31, SEG_RECIRC, 2), RESP_OKAY);
    axi_wr(REG_SEG3, seg(40, 41, SEG_DIRECT, 2), RESP_OKAY);
    for (int c = 1; c < 7; c++) begin
      last = (c - 1) % 3 + 1;
      axi_wr(REG_CTL, EN | (32'(c) << CTL_IPC_LO), RESP_OKAY);
      i_host.strobe();
      wait_addr(4);
      step(5, 0);
      for (int p = 1; p <= last; p++) begin
        step(pb[p], 0);
        step(pb[p] + 10'd1, 2);
      end
      if (c < 4) begin
        hold(8);
        chk(sweep_running === 1'b0, "burst did not stop");
        i_host.set_pins(2'(c));
        hold(4);
      end else begin
        step(4, 0);
      end
    end
    axi_wr(REG_CTL, EN | (32'h7 << CTL_IPC_LO), RESP_OKAY);
    i_host.strobe();
    wait_addr(40);
    axi_rd(REG_STATUS, d, r);
    chk(d[9:0] === 10'd40 && d[17:16] === 2'd3 && r === RESP_OKAY, "status");
  endtask
  task automatic t_dest();
    axi_wr(REG_CTL, EN | (32'h1 << CTL_DEST), RESP_OKAY);
    tick();
    chk(ram_to_phase === 1'b0, "destination moved before transfer");
    i_host.strobe();
    tick();
    chk(ram_to_phase === 1'b1, "destination not applied");
  endtask
  initial begin
    awaddr <= '0;
    awvalid <= 1'b0;
    wdata <= '0;
    wstrb <= 4'hf;
    wvalid <= 1'b0;
    bready <= 1'b0;
    araddr <= '0;
    arvalid <= 1'b0;
    rready <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_sweeps();
    t_nodwell();
    t_bidir();
    t_internal();
    t_dest();
    end_sim();
  end
endmodule
